// ===== hdl/bpsh_host.sv
// Purpose: host controller issuing bypass program, buffer and suspend commands
// Assumes: device already in bypass mode; done bit sampled synchronously
// Notes:   a request that the tracked device state cannot take is refused
`timescale 1ns/10ps
`include "bpsh_consts.svh"
module bpsh_host
	import bpsh_pkg::*;
#(
	parameter int WR_CYC  = `BPSH_WR_CYC,
	parameter int PSL_CYC = `BPSH_PSL_CYC,
	parameter int MAX_WC  = `BPSH_MAX_WC
) (
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        ce_i,
	input  wire bpsh_req_t   req_i,
	input  wire logic        req_valid_i,
	output logic             req_ready_o,
	output logic             req_refused_o,
	input  wire logic        prog_done_i,
	input  wire logic        prog_fail_i,
	input  wire logic        status_done_bit_i,
	output logic             flash_we_n_o,
	output bpsh_bus_t        flash_bus_o,
	output bpsh_state_t      dev_state_o,
	output logic             suspended_o
);

	initial begin
		if (PSL_CYC < 1 || PSL_CYC > 65535) $error("PSL_CYC out of range");
		if (MAX_WC != `BPSH_MAX_WC) $error("MAX_WC must match buffer size");
	end

	// ********************************************************************
	// state
	// ********************************************************************
	bpsh_state_t st_r, st_nxt;            // device state as tracked
	logic        nest_r, nest_nxt;        // program nested in erase suspend
	logic [22:0] sect_r, sect_nxt;        // entered_sector_address
	logic [8:0]  wc_r, wc_nxt;            // remaining_word_count, -1 is all ones
	logic [15:0] psl_r, psl_nxt;          // suspend latency counter
	logic        start;                   // launch a bus write
	bpsh_bus_t   word;                    // word to write
	logic        wr_busy;                 // write cycle in progress
	logic        accept;                  // request taken
	logic        refuse;                  // request refused
	logic        wc_neg;                  // count has reached -1
	logic        ok_sector;               // current sector matches

	assign wc_neg    = wc_r[8];
	assign ok_sector = req_i.addr[22:15] == sect_r[22:15];

	// ********************************************************************
	// command decode and state tracking
	// ********************************************************************
	always_comb begin
		st_nxt   = st_r;
		nest_nxt = nest_r;
		sect_nxt = sect_r;
		wc_nxt   = wc_r;
		psl_nxt  = psl_r;
		start    = 1'b0;
		refuse   = 1'b0;
		word     = '{addr: req_i.addr, data: req_i.data};
		accept   = req_valid_i && !wr_busy;
		unique case (st_r)
			BPSH_BYPASS_IDLE, BPSH_PROGRAMMING_ERROR_STATE: begin
				if (accept) begin
					unique case (req_i.op)
						BPSH_OP_WORD_PG: begin
							word     = '{addr: req_i.addr, data: `BPSH_CMD_WORD_PG};
							start    = 1'b1;
							nest_nxt = req_i.nest;
							st_nxt   = BPSH_BYPASS_WORD_PROGRAM_ENTRY;
						end
						BPSH_OP_BUF_PG: begin
							word     = '{addr: req_i.addr, data: `BPSH_CMD_BUF_LOAD};
							start    = 1'b1;
							nest_nxt = req_i.nest;
							sect_nxt = req_i.addr;
							st_nxt   = BPSH_BYPASS_BUFFER_LOAD_START;
						end
						default: refuse = 1'b1;
					endcase
				end
			end
			BPSH_BYPASS_WORD_PROGRAM_ENTRY: begin
				if (accept && req_i.op == BPSH_OP_BUF_DATA) begin
					start  = 1'b1;
					// next data write is the word; program then starts
					st_nxt = nest_r ? BPSH_ERASE_SUSP_PROGRAMMING : BPSH_BYPASS_PROGRAMMING;
				end else if (accept) begin
					refuse = 1'b1;
				end
			end
			BPSH_BYPASS_BUFFER_LOAD_START: begin
				if (accept && req_i.op == BPSH_OP_BUF_DATA) begin
					start  = 1'b1;
					wc_nxt = {1'b0, req_i.data[7:0]};
					// count too large or foreign sector sends device to error
					if (req_i.data > 16'(MAX_WC) || !ok_sector)
						st_nxt = BPSH_PROGRAMMING_ERROR_STATE;
					else
						st_nxt = BPSH_BYPASS_BUFFER_DATA_LOAD;
				end else if (accept) begin
					refuse = 1'b1;
				end
			end
			BPSH_BYPASS_BUFFER_DATA_LOAD: begin
				if (accept && req_i.op == BPSH_OP_BUF_DATA && !wc_neg) begin
					start  = 1'b1;
					wc_nxt = wc_r - 9'h001;
					if (!ok_sector)
						st_nxt = BPSH_PROGRAMMING_ERROR_STATE;
				end else if (accept && req_i.op == BPSH_OP_CONFIRM && wc_neg) begin
					word   = '{addr: req_i.addr, data: `BPSH_CMD_CONFIRM};
					start  = 1'b1;
					if (ok_sector)
						st_nxt = nest_r ? BPSH_ERASE_SUSP_PROGRAMMING : BPSH_BYPASS_PROGRAMMING;
					else
						st_nxt = BPSH_PROGRAMMING_ERROR_STATE;
				end else if (accept) begin
					refuse = 1'b1;
				end
			end
			BPSH_BYPASS_PROGRAMMING, BPSH_ERASE_SUSP_PROGRAMMING: begin
				if (prog_done_i && !prog_fail_i) begin
					// a request meeting the end of the program is turned away; retry in idle
					st_nxt = BPSH_BYPASS_IDLE;
					refuse = accept;
				end else if (accept && !status_done_bit_i && req_i.op == BPSH_OP_SUSPEND) begin
					// enhanced code preferred over the legacy one
					word    = '{addr: req_i.addr, data: `BPSH_CMD_SUSP_E};
					start   = 1'b1;
					psl_nxt = 16'(PSL_CYC);
					st_nxt  = nest_r ? BPSH_ERASE_SUSP_SUSPEND_REQUEST : BPSH_BYPASS_SUSPEND_REQUEST;
				end else if (accept && !status_done_bit_i && req_i.op == BPSH_OP_SR_READ) begin
					word  = '{addr: `BPSH_ADDR_UNLOCK, data: `BPSH_CMD_SR_READ};
					start = 1'b1;
				end else if (accept && status_done_bit_i && req_i.op == BPSH_OP_RESET) begin
					// hang: reset command frees the device
					word   = '{addr: req_i.addr, data: `BPSH_CMD_RESET};
					start  = 1'b1;
					st_nxt = BPSH_BYPASS_IDLE;
				end else if (accept) begin
					refuse = 1'b1;
				end
			end
			BPSH_BYPASS_SUSPEND_REQUEST, BPSH_ERASE_SUSP_SUSPEND_REQUEST: begin
				// latency runs from the strobe rise, so the device is surely suspended by then
				if (wr_busy)
					psl_nxt = psl_r;
				else if (psl_r == 16'h0000)
					st_nxt = nest_r ? BPSH_ERASE_SUSP_PROG_SUSPENDED : BPSH_BYPASS_PROG_SUSPENDED;
				else
					psl_nxt = psl_r - 16'h0001;
				refuse = accept;
			end
			BPSH_BYPASS_PROG_SUSPENDED, BPSH_ERASE_SUSP_PROG_SUSPENDED: begin
				if (accept && req_i.op == BPSH_OP_RESUME) begin
					word   = '{addr: req_i.addr, data: `BPSH_CMD_RESUME_E};
					start  = 1'b1;
					st_nxt = nest_r ? BPSH_ERASE_SUSP_PROGRAMMING : BPSH_BYPASS_PROGRAMMING;
				end else if (accept && req_i.op == BPSH_OP_SR_READ) begin
					word  = '{addr: `BPSH_ADDR_UNLOCK, data: `BPSH_CMD_SR_READ};
					start = 1'b1;
				end else if (accept && req_i.op == BPSH_OP_RESET && nest_r) begin
					// written, but the device stays doubly suspended
					word  = '{addr: req_i.addr, data: `BPSH_CMD_RESET};
					start = 1'b1;
				end else if (accept) begin
					refuse = 1'b1;
				end
			end
			default: st_nxt = BPSH_BYPASS_IDLE;
		endcase
	end

	// registers
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_r   <= BPSH_BYPASS_IDLE;
			nest_r <= 1'b0;
			sect_r <= '0;
			wc_r   <= '0;
			psl_r  <= '0;
		end else if (ce_i) begin
			st_r   <= st_nxt;
			nest_r <= nest_nxt;
			sect_r <= sect_nxt;
			wc_r   <= wc_nxt;
			psl_r  <= psl_nxt;
		end
	end

	// ********************************************************************
	// bus write engine
	// ********************************************************************
	bpsh_write_cycle #(
		.WR_CYC (WR_CYC)
	) u_wr (
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.ce_i     (ce_i),
		.start_i  (start && ce_i),
		.bus_i    (word),
		.busy_o   (wr_busy),
		.done_o   (),
		.we_n_o   (flash_we_n_o),
		.bus_o    (flash_bus_o)
	);

	assign req_ready_o   = !wr_busy && !refuse;
	assign req_refused_o = refuse;
	assign dev_state_o   = st_r;
	assign suspended_o   = (st_r == BPSH_BYPASS_PROG_SUSPENDED) || (st_r == BPSH_ERASE_SUSP_PROG_SUSPENDED);

	// ********************************************************************
	// checks
	// ********************************************************************
	chk_suspend_lat: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && st_r == BPSH_BYPASS_PROGRAMMING && st_nxt == BPSH_BYPASS_SUSPEND_REQUEST)
		|=> !suspended_o [*3]) else $error("suspend reported too early");
	chk_buf_error: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && st_r == BPSH_BYPASS_BUFFER_LOAD_START && start && req_i.data > 16'(MAX_WC))
		|=> st_r == BPSH_PROGRAMMING_ERROR_STATE) else $error("oversize count not flagged");
	chk_wc_step: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && st_r == BPSH_BYPASS_BUFFER_DATA_LOAD && start && req_i.op == BPSH_OP_BUF_DATA)
		|=> wc_r == $past(wc_r) - 9'h001) else $error("word count not decremented");
	chk_confirm_code: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && start && req_i.op == BPSH_OP_CONFIRM) |=> flash_bus_o.data == `BPSH_CMD_CONFIRM)
		else $error("confirm code wrong");
	chk_susp_code: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && start && req_i.op == BPSH_OP_SUSPEND) |=> !flash_we_n_o && flash_bus_o.data == `BPSH_CMD_SUSP_E)
		else $error("suspend code wrong");
	chk_double_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && st_r == BPSH_ERASE_SUSP_PROG_SUSPENDED && req_i.op != BPSH_OP_RESUME)
		|=> st_r == BPSH_ERASE_SUSP_PROG_SUSPENDED) else $error("double suspend left");
	chk_done_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && st_r == BPSH_BYPASS_PROGRAMMING && prog_done_i && !prog_fail_i)
		|=> st_r == BPSH_BYPASS_IDLE) else $error("no return to idle");
	chk_hang_reset: assert property (@(posedge clk_i) disable iff (!arst_n_i)
		(ce_i && start && req_i.op == BPSH_OP_RESET && !nest_r) |-> status_done_bit_i)
		else $error("reset issued without hang");

endmodule

// ===== hdl/bpsh_consts.svh
// Purpose: constants for the bypass program/suspend host controller
// Assumes: 16-bit data bus, word addressing, 100 MHz clock
// Notes:   command codes, addresses and timing counts live here
//
// What this block does
// - resume double suspend with 30h or 50h
// - host prefers enhanced suspend and resume codes
// - confirm 29h to same sector starts programming
// - suspend running program with B0h or 51h
// - hang with done bit: F0h returns idle
// - resume program suspend with 30h or 50h
`ifndef BPSH_CONSTS_SVH
`define BPSH_CONSTS_SVH

// ********************************************************************
// command codes and addresses
// ********************************************************************
`define BPSH_ADDR_UNLOCK   23'h000555
`define BPSH_CMD_SR_READ   16'h0070
`define BPSH_CMD_RESUME_L  16'h0030
`define BPSH_CMD_RESUME_E  16'h0050
`define BPSH_CMD_SUSP_L    16'h00B0
`define BPSH_CMD_SUSP_E    16'h0051
`define BPSH_CMD_RESET     16'h00F0
`define BPSH_CMD_WORD_PG   16'h00A0
`define BPSH_CMD_BUF_LOAD  16'h0025
`define BPSH_CMD_CONFIRM   16'h0029

// ********************************************************************
// limits and timing
// ********************************************************************
`define BPSH_MAX_WC        127
`define BPSH_STATUS_BIT    7
`define BPSH_PSL_NS        5000
`define BPSH_CLK_NS        10
`define BPSH_PSL_CYC       ((`BPSH_PSL_NS + `BPSH_CLK_NS - 1) / `BPSH_CLK_NS)
`define BPSH_WR_CYC        3

`endif

// ===== hdl/bpsh_pkg.sv
// Purpose: types for the bypass program/suspend host controller
// Assumes: 23-bit word address, 16-bit data
// Notes:   host-side command set and tracked device state
package bpsh_pkg;

	// ********************************************************************
	// host commands
	// ********************************************************************
	typedef enum logic [3:0] {
		BPSH_OP_NONE     = 4'h0, // no request
		BPSH_OP_WORD_PG  = 4'h1, // program one word
		BPSH_OP_BUF_PG   = 4'h2, // start buffer load
		BPSH_OP_BUF_DATA = 4'h3, // one buffer word
		BPSH_OP_CONFIRM  = 4'h4, // buffer to flash
		BPSH_OP_SUSPEND  = 4'h5, // program suspend
		BPSH_OP_RESUME   = 4'h6, // program resume
		BPSH_OP_SR_READ  = 4'h7, // status read entry
		BPSH_OP_RESET    = 4'h8  // software reset / exit
	} bpsh_op_t;

	// tracked device state, named as the device calls its states
	typedef enum logic [3:0] {
		BPSH_BYPASS_IDLE                = 4'h0,
		BPSH_BYPASS_WORD_PROGRAM_ENTRY  = 4'h1,
		BPSH_BYPASS_BUFFER_LOAD_START   = 4'h2,
		BPSH_BYPASS_BUFFER_DATA_LOAD    = 4'h3,
		BPSH_BYPASS_PROGRAMMING         = 4'h4,
		BPSH_BYPASS_SUSPEND_REQUEST     = 4'h5,
		BPSH_BYPASS_PROG_SUSPENDED      = 4'h6,
		BPSH_ERASE_SUSP_PROGRAMMING     = 4'h7,
		BPSH_ERASE_SUSP_PROG_SUSPENDED  = 4'h8,
		BPSH_PROGRAMMING_ERROR_STATE    = 4'h9,
		BPSH_ERASE_SUSP_SUSPEND_REQUEST = 4'hA
	} bpsh_state_t;

	// request from the user side
	typedef struct packed {
		bpsh_op_t    op;   // command
		logic [22:0] addr; // word address
		logic [15:0] data; // data or word count
		logic        nest; // program runs inside a suspended erase
	} bpsh_req_t;

	// one bus write cycle toward the flash
	typedef struct packed {
		logic [22:0] addr;
		logic [15:0] data;
	} bpsh_bus_t;

endpackage

// ===== hdl/bpsh_write_cycle.sv
// Purpose: drives one flash bus write cycle, we_n low for a fixed count
// Assumes: address and data held by this module for the whole cycle
// Notes:   busy while the strobe is out; done pulses one cycle at the end
`timescale 1ns/10ps
`include "bpsh_consts.svh"
module bpsh_write_cycle
	import bpsh_pkg::*;
#(
	parameter int WR_CYC = `BPSH_WR_CYC
) (
	input  wire logic      clk_i,
	input  wire logic      arst_n_i,
	input  wire logic      ce_i,
	input  wire logic      start_i,
	input  wire bpsh_bus_t bus_i,
	output logic           busy_o,
	output logic           done_o,
	output logic           we_n_o,
	output bpsh_bus_t      bus_o
);

	initial begin
		if (WR_CYC < 1 || WR_CYC > 255) $error("WR_CYC out of range");
	end

	// ********************************************************************
	// strobe counter
	// ********************************************************************
	logic [7:0] cnt_r, cnt_nxt;     // cycles left in strobe
	logic       we_n_r, we_n_nxt;   // registered strobe
	logic       done_r, done_nxt;   // end pulse
	bpsh_bus_t  bus_r, bus_nxt;     // held address and data

	// next-state of the strobe
	always_comb begin
		cnt_nxt  = cnt_r;
		we_n_nxt = we_n_r;
		done_nxt = 1'b0;
		bus_nxt  = bus_r;
		if (we_n_r && start_i) begin
			// latch the word and drop the strobe
			bus_nxt  = bus_i;
			we_n_nxt = 1'b0;
			cnt_nxt  = 8'(WR_CYC - 1);
		end else if (!we_n_r) begin
			if (cnt_r == 8'h00) begin
				// rising edge commits the write
				we_n_nxt = 1'b1;
				done_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r - 8'h01;
			end
		end
	end

	// registers
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_r  <= 8'h00;
			we_n_r <= 1'b1;
			done_r <= 1'b0;
			bus_r  <= '0;
		end else if (ce_i) begin
			cnt_r  <= cnt_nxt;
			we_n_r <= we_n_nxt;
			done_r <= done_nxt;
			bus_r  <= bus_nxt;
		end
	end

	assign busy_o = !we_n_r;
	assign done_o = done_r;
	assign we_n_o = we_n_r;
	assign bus_o  = bus_r;

endmodule

// ===== dv/bpsh_flash_model.sv
// Purpose: behavioural model of the flash command machine seen by the bypass host
// Assumes: one write is taken one cycle after each rise of the write strobe; sector is addr[22:15]
// Notes:   hang_i makes the next program end with the done bit stuck high
`timescale 1ns/10ps
module bpsh_flash_model
	import bpsh_pkg::*;
#(
	parameter int PROG_CYC = 60,
	parameter int PSL_CYC  = 4
) (
	input  wire logic         clk_i,
	input  wire logic         arst_n_i,
	input  wire logic         we_n_i,
	input  wire bpsh_bus_t    bus_i,
	input  wire logic         nest_i,
	input  wire logic         hang_i,
	output logic              prog_done_o,
	output logic              prog_fail_o,
	output logic              status_done_bit_o,
	output bpsh_state_t       state_o,
	output logic [15:0]       last_data_o,
	output logic [15:0]       wr_cnt_o
);
	// ********************************************************************
	// state and write decoding
	// ********************************************************************
	logic        we_q;  // strobe one cycle ago
	logic [7:0]  sect;  // sector entered with the buffer command
	logic [8:0]  wc;    // remaining word count, all ones is -1
	logic [15:0] d;     // data of the current write
	logic        same;  // current write hits the entered sector
	int          tmr;   // program and suspend latency timer
	assign d    = bus_i.data;
	assign same = (bus_i.addr[22:15] == sect);

	// command machine: a write is taken one cycle after the strobe rises
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			we_q              <= 1'b1;
			sect              <= 8'h00;
			wc                <= 9'h000;
			tmr               <= 0;
			state_o           <= BPSH_BYPASS_IDLE;
			prog_done_o       <= 1'b0;
			prog_fail_o       <= 1'b0;
			status_done_bit_o <= 1'b0;
			last_data_o       <= 16'h0000;
			wr_cnt_o          <= 16'h0000;
		end else begin
			we_q        <= we_n_i;
			prog_done_o <= 1'b0;
			prog_fail_o <= 1'b0;
			tmr         <= tmr + 1;
			if (!we_q && we_n_i) begin
				wr_cnt_o    <= wr_cnt_o + 16'h0001;
				last_data_o <= d;
				case (state_o)
				BPSH_BYPASS_IDLE, BPSH_PROGRAMMING_ERROR_STATE: begin
					// other codes are ignored here
					if (d == 16'h00A0) begin
						state_o <= BPSH_BYPASS_WORD_PROGRAM_ENTRY;
					end else if (d == 16'h0025) begin
						state_o <= BPSH_BYPASS_BUFFER_LOAD_START;
						sect    <= bus_i.addr[22:15];
					end
				end
				BPSH_BYPASS_WORD_PROGRAM_ENTRY: begin
					state_o <= nest_i ? BPSH_ERASE_SUSP_PROGRAMMING : BPSH_BYPASS_PROGRAMMING;
					tmr     <= 0;
				end
				BPSH_BYPASS_BUFFER_LOAD_START: begin
					wc      <= d[8:0];
					state_o <= (d > 16'h007F || !same) ? BPSH_PROGRAMMING_ERROR_STATE :
						BPSH_BYPASS_BUFFER_DATA_LOAD;
				end
				BPSH_BYPASS_BUFFER_DATA_LOAD: begin
					if (wc != 9'h1FF) begin
						wc <= wc - 9'h001;
						if (!same) state_o <= BPSH_PROGRAMMING_ERROR_STATE;
					end else if (d == 16'h0029 && same) begin
						state_o <= BPSH_BYPASS_PROGRAMMING;
						tmr     <= 0;
					end else begin
						state_o <= BPSH_PROGRAMMING_ERROR_STATE;
					end
				end
				BPSH_BYPASS_PROGRAMMING, BPSH_ERASE_SUSP_PROGRAMMING: begin
					// a status read leaves the program running
					if (!status_done_bit_o && (d == 16'h00B0 || d == 16'h0051)) begin
						state_o <= (state_o == BPSH_BYPASS_PROGRAMMING) ? BPSH_BYPASS_SUSPEND_REQUEST :
							BPSH_ERASE_SUSP_SUSPEND_REQUEST;
						tmr     <= 0;
					end else if (status_done_bit_o && d == 16'h00F0) begin
						state_o           <= BPSH_BYPASS_IDLE;
						status_done_bit_o <= 1'b0;
					end
				end
				BPSH_BYPASS_PROG_SUSPENDED: begin
					if (d == 16'h0030 || d == 16'h0050) begin
						state_o <= BPSH_BYPASS_PROGRAMMING;
						tmr     <= 0;
					end
				end
				BPSH_ERASE_SUSP_PROG_SUSPENDED: begin
					// status read and reset keep the double suspend
					if (d == 16'h0030 || d == 16'h0050) begin
						state_o <= BPSH_ERASE_SUSP_PROGRAMMING;
						tmr     <= 0;
					end
				end
				default: begin
				end
				endcase
			end else begin
				case (state_o)
				BPSH_BYPASS_PROGRAMMING, BPSH_ERASE_SUSP_PROGRAMMING: begin
					if (!status_done_bit_o && tmr == PROG_CYC) begin
						prog_done_o <= 1'b1;
						if (hang_i) begin
							prog_fail_o       <= 1'b1;
							status_done_bit_o <= 1'b1;
						end else begin
							state_o <= BPSH_BYPASS_IDLE;
						end
					end
				end
				BPSH_BYPASS_SUSPEND_REQUEST: begin
					if (tmr == PSL_CYC - 1) state_o <= BPSH_BYPASS_PROG_SUSPENDED;
				end
				BPSH_ERASE_SUSP_SUSPEND_REQUEST: begin
					if (tmr == PSL_CYC - 1) state_o <= BPSH_ERASE_SUSP_PROG_SUSPENDED;
				end
				default: begin
				end
				endcase
			end
		end
	end
endmodule

// ===== dv/bypass_program_suspend_fsm_tb.sv
// Purpose: self-checking bench for the bypass program/suspend host controller
// Assumes: write cycle of 3 clocks, suspend latency shortened to 4 clocks
// Notes:   the flash model answers every write and reports its own state
`timescale 1ns/10ps
module bypass_program_suspend_fsm_tb
	import bpsh_pkg::*;
;
	// ********************************************************************
	// signals
	// ********************************************************************
	localparam int WR  = 3;
	localparam int PSL = 4;
	logic        clk, arst_n, req_valid, req_ready, req_refused;
	logic        prog_done, prog_fail, status_bit, we_n, suspended, nest, hang;
	bpsh_req_t   req;
	bpsh_bus_t   bus;
	bpsh_state_t dev_state, m_state;
	logic [15:0] last_data, wr_cnt;
	int          error_cnt, cmp_count, cyc, n;

	bpsh_host #(.WR_CYC(WR), .PSL_CYC(PSL), .MAX_WC(127)) i_dut (.clk_i(clk), .arst_n_i(arst_n), .ce_i(1'b1),
		.req_i(req), .req_valid_i(req_valid), .req_ready_o(req_ready), .req_refused_o(req_refused),
		.prog_done_i(prog_done), .prog_fail_i(prog_fail), .status_done_bit_i(status_bit),
		.flash_we_n_o(we_n), .flash_bus_o(bus), .dev_state_o(dev_state), .suspended_o(suspended));
	bpsh_flash_model #(.PROG_CYC(60), .PSL_CYC(PSL)) i_flash (.clk_i(clk), .arst_n_i(arst_n), .we_n_i(we_n),
		.bus_i(bus), .nest_i(nest), .hang_i(hang), .prog_done_o(prog_done), .prog_fail_o(prog_fail),
		.status_done_bit_o(status_bit), .state_o(m_state), .last_data_o(last_data), .wr_cnt_o(wr_cnt));

	// ********************************************************************
	// shared tasks
	// ********************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// hold the request until ready, then wait out the flash write
	task automatic issue(input bpsh_op_t op, input logic [22:0] a, input logic [15:0] d, input logic ns);
		logic [15:0] w;
		int          k;
		w = wr_cnt;
		k = 0;
		@(negedge clk);
		req       = '{op: op, addr: a, data: d, nest: ns};
		nest      = ns;
		req_valid = 1'b1;
		#1;
		while (req_ready !== 1'b1 && k < 50) begin
			@(negedge clk);
			k++;
		end
		chk(k < 50, 1);
		@(negedge clk);
		req_valid = 1'b0;
		repeat (WR + 3) @(negedge clk);
		chk(wr_cnt, w + 16'h0001);
	endtask

	// an op the tracked state cannot take is refused and writes nothing
	task automatic try_refused(input bpsh_op_t op);
		logic [15:0] w;
		w = wr_cnt;
		@(negedge clk);
		req       = '{op: op, addr: 23'h000000, data: 16'h0000, nest: 1'b0};
		req_valid = 1'b1;
		@(negedge clk);
		chk({req_refused, req_ready}, 32'h2);
		req_valid = 1'b0;
		repeat (6) @(negedge clk);
		chk(wr_cnt, w);
	endtask

	task automatic wait_state(input bpsh_state_t s, input int lim);
		n = 0;
		while (dev_state !== s && n < lim) begin
			@(negedge clk);
			n++;
		end
		chk(n < lim, 1);
	endtask

	task automatic complete_run;
		$display("comparisons=%0d mismatches=%0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ********************************************************************
	// scenarios
	// ********************************************************************
	// word program, status read while busy, clean completion
	task automatic t_word;
		issue(BPSH_OP_WORD_PG, 23'h010000, 16'h0000, 1'b0);
		chk(dev_state, BPSH_BYPASS_WORD_PROGRAM_ENTRY);
		chk(last_data, 16'h00A0);
		issue(BPSH_OP_BUF_DATA, 23'h010004, 16'h1234, 1'b0);
		chk(dev_state, BPSH_BYPASS_PROGRAMMING);
		chk(last_data, 16'h1234);
		issue(BPSH_OP_SR_READ, 23'h000555, 16'h0070, 1'b0);
		chk(dev_state, BPSH_BYPASS_PROGRAMMING);
		chk(m_state, BPSH_BYPASS_PROGRAMMING);
		wait_state(BPSH_BYPASS_IDLE, 200);
		chk(m_state, BPSH_BYPASS_IDLE);
	endtask

	// full buffer of 128 words, early confirm refused, suspend and resume
	task automatic t_buffer;
		issue(BPSH_OP_BUF_PG, 23'h018000, 16'h0000, 1'b0);
		issue(BPSH_OP_BUF_DATA, 23'h018000, 16'h007F, 1'b0);
		chk(dev_state, BPSH_BYPASS_BUFFER_DATA_LOAD);
		for (int i = 0; i < 128; i++) begin
			if (i == 127) try_refused(BPSH_OP_CONFIRM);
			issue(BPSH_OP_BUF_DATA, 23'h018000 + 23'(i), 16'(i), 1'b0);
		end
		chk(m_state, BPSH_BYPASS_BUFFER_DATA_LOAD);
		issue(BPSH_OP_CONFIRM, 23'h018000, 16'h0029, 1'b0);
		chk(dev_state, BPSH_BYPASS_PROGRAMMING);
		chk(last_data, 16'h0029);
		issue(BPSH_OP_SUSPEND, 23'h000000, 16'h0051, 1'b0);
		chk(last_data, 16'h0051);
		wait_state(BPSH_BYPASS_PROG_SUSPENDED, PSL + 2);
		chk(suspended, 1'b1);
		chk(m_state, BPSH_BYPASS_PROG_SUSPENDED);
		issue(BPSH_OP_SR_READ, 23'h000555, 16'h0070, 1'b0);
		chk(dev_state, BPSH_BYPASS_PROG_SUSPENDED);
		issue(BPSH_OP_RESUME, 23'h000000, 16'h0050, 1'b0);
		chk(last_data, 16'h0050);
		chk(dev_state, BPSH_BYPASS_PROGRAMMING);
		wait_state(BPSH_BYPASS_IDLE, 200);
	endtask

	// count too large, sector mismatch at start, confirm or data to another sector
	task automatic t_errors;
		for (int c = 0; c < 4; c++) begin
			issue(BPSH_OP_BUF_PG, 23'h018000, 16'h0000, 1'b0);
			issue(BPSH_OP_BUF_DATA, c == 1 ? 23'h020000 : 23'h018000, c == 0 ? 16'h0080 : 16'h0000, 1'b0);
			if (c >= 2) begin
				issue(BPSH_OP_BUF_DATA, c == 3 ? 23'h020001 : 23'h018001, 16'h0001, 1'b0);
			end
			if (c == 2) begin
				issue(BPSH_OP_CONFIRM, 23'h020000, 16'h0029, 1'b0);
			end
			chk(dev_state, BPSH_PROGRAMMING_ERROR_STATE);
			chk(m_state, BPSH_PROGRAMMING_ERROR_STATE);
		end
		try_refused(BPSH_OP_RESUME);
	endtask

	// program hangs with the done bit high; reset returns to idle
	task automatic t_hang;
		hang = 1'b1;
		issue(BPSH_OP_WORD_PG, 23'h010000, 16'h0000, 1'b0);
		issue(BPSH_OP_BUF_DATA, 23'h010008, 16'h5A5A, 1'b0);
		n = 0;
		while (status_bit !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		repeat (3) @(negedge clk);
		chk(status_bit, 1'b1);
		chk(dev_state, BPSH_BYPASS_PROGRAMMING);
		issue(BPSH_OP_RESET, 23'h000000, 16'h00F0, 1'b0);
		chk(last_data, 16'h00F0);
		chk(dev_state, BPSH_BYPASS_IDLE);
		hang = 1'b0;
	endtask

	// program nested in erase suspend, doubly suspended, then mid-run reset
	task automatic t_nest;
		issue(BPSH_OP_WORD_PG, 23'h010000, 16'h0000, 1'b1);
		issue(BPSH_OP_BUF_DATA, 23'h01000C, 16'hC3C3, 1'b1);
		chk(dev_state, BPSH_ERASE_SUSP_PROGRAMMING);
		issue(BPSH_OP_SUSPEND, 23'h000000, 16'h0051, 1'b1);
		wait_state(BPSH_ERASE_SUSP_PROG_SUSPENDED, PSL + 2);
		chk(m_state, BPSH_ERASE_SUSP_PROG_SUSPENDED);
		issue(BPSH_OP_SR_READ, 23'h000555, 16'h0070, 1'b1);
		chk(dev_state, BPSH_ERASE_SUSP_PROG_SUSPENDED);
		issue(BPSH_OP_RESET, 23'h000000, 16'h00F0, 1'b1);
		chk(dev_state, BPSH_ERASE_SUSP_PROG_SUSPENDED);
		chk(m_state, BPSH_ERASE_SUSP_PROG_SUSPENDED);
		issue(BPSH_OP_RESUME, 23'h000000, 16'h0050, 1'b1);
		chk(dev_state, BPSH_ERASE_SUSP_PROGRAMMING);
		@(negedge clk);
		arst_n = 1'b0;
		@(negedge clk);
		chk({we_n, dev_state}, {1'b1, BPSH_BYPASS_IDLE});
		arst_n = 1'b1;
	endtask

	// ********************************************************************
	// clock, timeout and main sequence
	// ********************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// cut a hang short well above the expected run of under two thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			complete_run;
		end
	end

	initial begin
		arst_n    = 1'b0;
		req       = '0;
		req_valid = 1'b0;
		nest      = 1'b0;
		hang      = 1'b0;
		error_cnt = 0;
		cmp_count = 0;
		cyc       = 0;
		repeat (2) @(negedge clk);
		arst_n = 1'b1;
		chk({we_n, suspended, dev_state}, {2'b10, BPSH_BYPASS_IDLE});
		try_refused(BPSH_OP_SUSPEND);
		t_word;
		t_buffer;
		t_errors;
		t_hang;
		t_nest;
		complete_run;
	end
endmodule
